// >>> vfw_regs.svh
// Register indices, reset values, field positions and counts of the window selector.
// Assumes a 32-bit Wishbone slave where the byte address is four times the index.
`ifndef VFW_REGS_SVH
`define VFW_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define VFW_IDX_VSTART 10'h120
`define VFW_IDX_VSPAN 10'h121
`define VFW_IDX_VOUT 10'h122
`define VFW_IDX_HSTART 10'h123
`define VFW_IDX_DECIM 10'h130
`define VFW_IDX_STATUS 10'h131

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VFW_RST_VSTART 12'h00C
`define VFW_RST_VSPAN 12'h000
`define VFW_RST_VOUT 12'h000
`define VFW_RST_HSTART 12'h000
`define VFW_RST_DECIM 12'h000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VFW_LINE_MSB 8
`define VFW_DECIM_EN_BIT 9
`define VFW_FMODE_MSB 11
`define VFW_FMODE_LSB 10
`define VFW_HPOS_MSB 10
`define VFW_ST_ODD_BIT 9
`define VFW_ST_LIVE_BIT 10
`define VFW_ST_KEEP_BIT 11

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
// Length of the decimation interval in frames, 3000.
`define VFW_DECIM_INTERVAL 12'hBB8
`define VFW_LINE_MAX 9'h1FF
`define VFW_PIX_MAX 11'h7FF

`endif

// >>> vfw_pkg.sv
// Types shared by the window selector modules.
// Assumes nothing of its surroundings.
package vfw_pkg;

  // --------------------------------------------------------------------------
  // Field enable codes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VFW_BOTH = 2'b00,
    VFW_EVEN_ONLY = 2'b01,
    VFW_ODD_ONLY = 2'b10,
    VFW_OFF = 2'b11
  } vfw_field_mode_type;

endpackage

// >>> vfw_frame_decim.sv
// Frame decimator: keeps a programmed number of frames in every interval.
// Assumes one frame_tick_i pulse at the start of each frame.
`timescale 1ns/1ps
`include "vfw_regs.svh"

module vfw_frame_decim (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_tick_i,
  input wire logic enable_i,
  input wire logic [11:0] frames_i,
  output logic keep_o
);

  logic [11:0] acc_r;
  logic [11:0] frames_lim;
  logic [12:0] sum;
  logic hit;

  // ----------------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------------
  // A counts above the interval would overflow the accumulator, so they keep every frame.
  assign frames_lim = (frames_i > `VFW_DECIM_INTERVAL) ? `VFW_DECIM_INTERVAL : frames_i;
  assign sum = {1'b0, acc_r} + {1'b0, frames_lim};
  assign hit = (sum >= {1'b0, `VFW_DECIM_INTERVAL});

  // Spreading the kept frames evenly gives exactly frames_lim kept per interval.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 12'h000;
      keep_o <= 1'b1;
    end else if (frame_tick_i) begin
      if (!enable_i) begin
        acc_r <= 12'h000;
        keep_o <= 1'b1;
      end else if (hit) begin
        acc_r <= 12'(sum - {1'b0, `VFW_DECIM_INTERVAL}); // R9
        keep_o <= 1'b1;
      end else begin
        acc_r <= sum[11:0];
        keep_o <= 1'b0; // R9
      end
    end
  end

endmodule

// >>> vfw_line_drop.sv
// Vertical compression by line dropping: keeps out_span_i of every in_span_i lines.
// Assumes field_start_i before the first window line of a field.
`timescale 1ns/1ps
`include "vfw_regs.svh"

module vfw_line_drop (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic field_start_i,
  input wire logic line_tick_i,
  input wire logic [8:0] in_span_i,
  input wire logic [8:0] out_span_i,
  output logic keep_o
);

  logic [8:0] acc_r;
  logic [9:0] sum;
  logic pass_all;
  logic hit;

  // ----------------------------------------------------------------------------
  // Drop decision
  // ----------------------------------------------------------------------------
  // No interpolation exists, so an output count at or above the input count keeps all.
  assign pass_all = (out_span_i >= in_span_i); // R11
  assign sum = {1'b0, acc_r} + {1'b0, out_span_i};
  assign hit = (sum >= {1'b0, in_span_i});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 9'h000;
      keep_o <= 1'b0;
    end else if (field_start_i) begin
      acc_r <= 9'h000;
      keep_o <= 1'b0;
    end else if (line_tick_i) begin
      if (pass_all) begin
        keep_o <= 1'b1;
      end else if (hit) begin
        acc_r <= 9'(sum - {1'b0, in_span_i}); // R12
        keep_o <= 1'b1;
      end else begin
        acc_r <= sum[8:0];
        keep_o <= 1'b0; // R12
      end
    end
  end

endmodule

// >>> vfw_window_selector.sv
// Window selector for the first capture window: vertical window, field enable,
// line dropping, left cropping and frame decimation, programmed over Wishbone.
// Assumes line, field and pixel timing from decoder logic on the same clock.
//
// Operation
// R1: Bits 8:0 of the vertical start word give the window's first line.
// R2: On 625-line standards software never programs a start below line seven.
// R3: On 525-line standards software never programs a start below line ten.
// R4: Start line is limited by the detected standard's line count, not a constant.
// R5: Software writes zeros into the three unused upper bits of both line words.
// R6: Bits 8:0 of the input span word give the window height in lines.
// R7: A window running past the field end is cut at the last field line.
// R8: Bit 9 of the input span word switches frame decimation on or off.
// R9: With decimation on, only the programmed frames per 3000 are output.
// R10: Field code: 11 off, 10 odd only, 01 even only, 00 both fields.
// R11: Software keeps the output line count at or below the input line count.
// R12: Fewer output than input lines drops lines evenly to reach the output count.
// R13: Bits 10:0 of the horizontal start word give the window's first scaled pixel.
// R14: A nonzero horizontal start crops that many pixels from each line's left.
// R15: Pixel positions are counted in an 11-bit count of scaled active pixels.
// R16: Software keeps horizontal start plus length within the scaled active line.
// R17: Lines count from vertical sync; parity comes from the odd/even input.
`timescale 1ns/1ps
`include "vfw_regs.svh"

module vfw_window_selector (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vsync_i,
  input wire logic hsync_i,
  input wire logic field_odd_i,
  input wire logic [8:0] lines_per_field_i,
  input wire logic pix_valid_i,
  input wire logic [15:0] pix_data_i,
  output logic win_valid_o,
  output logic [15:0] win_data_o,
  output logic win_line_o,
  output logic win_field_odd_o
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Merges the two low byte lanes of a write into a 12-bit register.
  function automatic logic [11:0] lane_merge(input logic [11:0] old_v,
                                             input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [11:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[11:8] = dat[11:8];
    end
    return v;
  endfunction

  // Smaller of two 9-bit values.
  function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
    return (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  logic [11:0] vstart_r;
  logic [11:0] vspan_r;
  logic [11:0] vout_r;
  logic [11:0] hstart_r;
  logic [11:0] decim_r;
  logic [11:0] status;
  logic ack_nxt;
  logic [9:0] idx;
  logic wr_en;
  logic sel_vstart;
  logic sel_vspan;
  logic sel_vout;
  logic sel_hstart;
  logic sel_decim;
  logic sel_status;
  logic [31:0] rd_nxt;

  // Every index, mapped or not, is acknowledged, so a stray access never stalls the bus.
  assign idx = wb_adr_i[11:2];
  // Ack is registered and then drops for a cycle, so each access spans two clock edges.
  assign ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = ack_nxt & wb_we_i;
  assign sel_vstart = (idx == `VFW_IDX_VSTART);
  assign sel_vspan = (idx == `VFW_IDX_VSPAN);
  assign sel_vout = (idx == `VFW_IDX_VOUT);
  assign sel_hstart = (idx == `VFW_IDX_HSTART);
  assign sel_decim = (idx == `VFW_IDX_DECIM);
  assign sel_status = (idx == `VFW_IDX_STATUS);
  // The window words are write-only; only the decimation count and status read back.
  assign rd_nxt = sel_decim ? {20'h00000, decim_r} :
                  sel_status ? {20'h00000, status} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= ack_nxt ? rd_nxt : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vstart_r <= `VFW_RST_VSTART;
      vspan_r <= `VFW_RST_VSPAN;
      vout_r <= `VFW_RST_VOUT;
      hstart_r <= `VFW_RST_HSTART;
      decim_r <= `VFW_RST_DECIM;
    end else if (wr_en) begin
      if (sel_vstart) begin
        vstart_r <= lane_merge(vstart_r, wb_dat_i, wb_sel_i);
      end else if (sel_vspan) begin
        vspan_r <= lane_merge(vspan_r, wb_dat_i, wb_sel_i);
      end else if (sel_vout) begin
        vout_r <= lane_merge(vout_r, wb_dat_i, wb_sel_i);
      end else if (sel_hstart) begin
        hstart_r <= lane_merge(hstart_r, wb_dat_i, wb_sel_i);
      end else if (sel_decim) begin
        decim_r <= lane_merge(decim_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Field shadow
  // ----------------------------------------------------------------------------
  // Parameters are taken at vertical sync so a write never splits a field's window.
  logic [8:0] start_s_r;
  logic [8:0] span_s_r;
  logic [8:0] out_s_r;
  logic [10:0] hstart_s_r;
  vfw_pkg::vfw_field_mode_type fmode_s_r;
  logic field_odd_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_s_r <= 9'(`VFW_RST_VSTART);
      span_s_r <= 9'h000;
      out_s_r <= 9'h000;
      hstart_s_r <= 11'h000;
      fmode_s_r <= vfw_pkg::VFW_BOTH;
      field_odd_r <= 1'b0;
    end else if (vsync_i) begin
      start_s_r <= vstart_r[`VFW_LINE_MSB:0]; // R1
      span_s_r <= vspan_r[`VFW_LINE_MSB:0]; // R6
      out_s_r <= vout_r[`VFW_LINE_MSB:0];
      hstart_s_r <= hstart_r[`VFW_HPOS_MSB:0]; // R13
      fmode_s_r <= vfw_pkg::vfw_field_mode_type'(vspan_r[`VFW_FMODE_MSB:`VFW_FMODE_LSB]);
      field_odd_r <= field_odd_i; // R17
    end
  end

  // ----------------------------------------------------------------------------
  // Line counting and vertical window
  // ----------------------------------------------------------------------------
  logic [8:0] line_cnt_r;
  logic line_new_r;
  logic [8:0] start_lim;
  logic [8:0] room;
  logic [8:0] span_eff;
  logic [8:0] line_off;
  logic in_window;
  logic field_ok;
  logic frame_keep;

  // The count saturates, so an overlong field can never wrap back into the window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_cnt_r <= 9'h000;
      line_new_r <= 1'b0;
    end else begin
      line_new_r <= hsync_i & ~vsync_i;
      if (vsync_i) begin
        line_cnt_r <= 9'h000; // R17
      end else if (hsync_i && line_cnt_r != `VFW_LINE_MAX) begin
        line_cnt_r <= line_cnt_r + 9'h001; // R17
      end
    end
  end

  // The start is limited by the detected standard, then the span is cut to fit.
  assign start_lim = min9(start_s_r, lines_per_field_i); // R4
  assign room = lines_per_field_i - start_lim;
  assign span_eff = min9(span_s_r, room); // R7
  assign line_off = line_cnt_r - start_lim;
  assign in_window = (line_cnt_r >= start_lim) && (line_off < span_eff); // R6

  // Parity comes from the latch at vsync, so a late parity change waits for the next field.
  always_comb begin
    case (fmode_s_r)
      vfw_pkg::VFW_OFF: field_ok = 1'b0; // R10
      vfw_pkg::VFW_ODD_ONLY: field_ok = field_odd_r; // R10
      vfw_pkg::VFW_EVEN_ONLY: field_ok = ~field_odd_r; // R10
      default: field_ok = 1'b1; // R10
    endcase
  end

  // ----------------------------------------------------------------------------
  // Frame decimation and line dropping
  // ----------------------------------------------------------------------------
  logic frame_tick;
  logic line_tick;
  logic line_tick_d_r;
  logic line_keep;

  // A frame begins with its odd field.
  assign frame_tick = vsync_i & field_odd_i;
  assign line_tick = line_new_r & in_window & field_ok & frame_keep;

  // The enable is read live, not shadowed, so the frame tick at vsync sees the latest write.
  vfw_frame_decim u_decim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_tick_i(frame_tick),
    .enable_i(vspan_r[`VFW_DECIM_EN_BIT]), // R8
    .frames_i(decim_r),
    .keep_o(frame_keep)
  );

  vfw_line_drop u_drop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_start_i(vsync_i),
    .line_tick_i(line_tick),
    .in_span_i(span_eff),
    .out_span_i(out_s_r),
    .keep_o(line_keep)
  );

  // ----------------------------------------------------------------------------
  // Horizontal cropping and output
  // ----------------------------------------------------------------------------
  logic [10:0] pix_cnt_r;
  logic line_live_r;
  logic past_crop;
  logic pix_keep;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_tick_d_r <= 1'b0;
      line_live_r <= 1'b0;
    end else begin
      line_tick_d_r <= line_tick;
      if (hsync_i || vsync_i) begin
        line_live_r <= 1'b0;
      end else if (line_tick_d_r) begin
        line_live_r <= line_keep; // R12
      end
    end
  end

  // Pixels count from the line start; the count saturates on overlong lines.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_cnt_r <= 11'h000;
    end else if (hsync_i) begin
      pix_cnt_r <= 11'h000;
    end else if (pix_valid_i && pix_cnt_r != `VFW_PIX_MAX) begin
      pix_cnt_r <= pix_cnt_r + 11'h001; // R15
    end
  end

  // With no length register the window runs from the crop point to the line end.
  assign past_crop = (pix_cnt_r >= hstart_s_r); // R14
  // A pixel that comes with a sync pulse belongs to no window line and never passes.
  assign pix_keep = pix_valid_i & line_live_r & past_crop & ~(hsync_i | vsync_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_valid_o <= 1'b0;
      win_data_o <= 16'h0000;
      win_line_o <= 1'b0;
      win_field_odd_o <= 1'b0;
    end else begin
      win_valid_o <= pix_keep; // R14
      win_data_o <= pix_data_i;
      win_line_o <= line_live_r;
      win_field_odd_o <= field_odd_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------------
  // Status shows where the selector stands in the field, which eases bring-up.
  assign status = {frame_keep, line_live_r, field_odd_r, line_cnt_r};

endmodule

// >>> vfw_window_selector_chk.sv
// Concurrent checks on the ports of the window selector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module vfw_window_selector_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic vsync_i,
  input wire logic hsync_i,
  input wire logic field_odd_i,
  input wire logic pix_valid_i,
  input wire logic [15:0] pix_data_i,
  input wire logic win_valid_o,
  input wire logic win_line_o,
  input wire logic [15:0] win_data_o,
  input wire logic win_field_odd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:12] == 20'h00000)
    else $error("read data upper bits not zero");
  a_wo_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i[11:4] == 8'h48 |=> wb_dat_o == 32'h0000_0000)
    else $error("write-only window word read back nonzero");
  a_pix_pass: assert property (win_valid_o |->
    $past(pix_valid_i) && win_data_o == $past(pix_data_i))
    else $error("windowed pixel differs from input pixel");
  a_sync_gap: assert property (hsync_i |=> !win_valid_o [*3])
    else $error("pixel output within three cycles of line start");
  a_field_odd: assert property (vsync_i ##1 !vsync_i ##1 !vsync_i |->
    win_field_odd_o == $past(field_odd_i, 2))
    else $error("field parity not latched at field start");
  a_line_start: assert property ($rose(win_line_o) |-> $past(hsync_i, 4))
    else $error("window line flag rose without a line start");
  a_valid_line: assert property (win_valid_o |-> win_line_o)
    else $error("pixel output outside a kept window line");
endmodule

// >>> vfw_capture_sink.sv
// Downstream capture model: counts windowed pixels and keeps the first pixel
// of each burst. Assumes a gap of idle cycles between window lines.
`timescale 1ns/1ps

module vfw_capture_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic [15:0] data_i,
  output logic [15:0] count_o,
  output logic [15:0] first_o
);
  logic prev_r;

  // The sink never stalls, since the window output has no back-pressure.
  always_ff @(posedge clk_i) begin
    prev_r <= valid_i && !rst_i;
    if (rst_i) begin
      count_o <= 16'h0000;
    end else if (valid_i) begin
      count_o <= count_o + 16'h0001;
    end
    if (valid_i && !prev_r) begin
      first_o <= data_i;
    end
  end
endmodule

// >>> video_field_window_selector_test.sv
// Self-checking bench for the window selector with a capture sink model.
// Assumes the design answers a Wishbone request one cycle after taking it.
`timescale 1ns/1ps
`include "vfw_regs.svh"

module video_field_window_selector_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic vsync_i = 1'b0;
  logic hsync_i = 1'b0;
  logic field_odd_i = 1'b0;
  logic [8:0] lines_per_field_i = 9'h014;
  logic pix_valid_i = 1'b0;
  logic [15:0] pix_data_i = 16'h0000;
  logic win_valid_o;
  logic [15:0] win_data_o;
  logic win_line_o;
  logic win_field_odd_o;
  logic [15:0] cnt;
  logic [15:0] first;
  int num_errors = 0;
  int tests_run = 0;

  always #20 clk_i = ~clk_i;

  vfw_window_selector i_vfw_window_selector (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vsync_i,
    .hsync_i, .field_odd_i, .lines_per_field_i, .pix_valid_i, .pix_data_i,
    .win_valid_o, .win_data_o, .win_line_o, .win_field_odd_o);
  vfw_capture_sink i_vfw_capture_sink (.clk_i, .rst_i, .valid_i(win_valid_o),
    .data_i(win_data_o), .count_o(cnt), .first_o(first));

  task summarize;
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wb(input logic we, input logic [3:0] s, input logic [9:0] idx, input logic [11:0] d,
          output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {20'h00000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task wr(input logic [9:0] idx, input logic [11:0] d);
    logic [31:0] q;
    wb(1'b1, 4'hF, idx, d, q);
  endtask

  task rd(input logic [9:0] idx, input logic [11:0] exp);
    logic [31:0] q;
    wb(1'b0, 4'hF, idx, 12'h000, q);
    chk(q, {20'h00000, exp});
  endtask

  // Software side keeps starts legal, upper bits zero and output within input.
  task setw(input logic [11:0] st, input logic [11:0] sp, input logic [11:0] ou,
            input logic [11:0] hs);
    wr(`VFW_IDX_VSTART, st);
    wr(`VFW_IDX_VSPAN, sp);
    wr(`VFW_IDX_VOUT, ou);
    wr(`VFW_IDX_HSTART, hs);
  endtask

  task fld(input logic odd, input int nl, input int np);
    @(posedge clk_i);
    vsync_i <= 1'b1;
    field_odd_i <= odd;
    @(posedge clk_i);
    vsync_i <= 1'b0;
    repeat (nl) begin
      repeat (3) @(posedge clk_i);
      hsync_i <= 1'b1;
      @(posedge clk_i);
      hsync_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int k = 0; k < np; k++) begin
        pix_valid_i <= 1'b1;
        pix_data_i <= k[15:0];
        @(posedge clk_i);
      end
      pix_valid_i <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
  endtask

  task fcnt(input logic odd, input int nl, input int np, input logic [15:0] exp);
    logic [15:0] base;
    base = cnt;
    fld(odd, nl, np);
    chk({16'h0000, cnt - base}, {16'h0000, exp});
  endtask

  task t_regs;
    logic [31:0] q;
    rd(`VFW_IDX_STATUS, 12'h800);
    rd(`VFW_IDX_VSTART, 12'h000);
    wr(10'h1FF, 12'hABC);
    rd(10'h1FF, 12'h000);
    wr(`VFW_IDX_DECIM, 12'h5DC);
    rd(`VFW_IDX_DECIM, 12'h5DC);
    wb(1'b1, 4'h2, `VFW_IDX_DECIM, 12'h3FF, q);
    rd(`VFW_IDX_DECIM, 12'h3DC);
  endtask

  task t_window;
    setw(12'h00A, 12'h003, 12'h003, 12'h000);
    fcnt(1'b1, 14, 4, 16'h000C);
    chk({16'h0000, first}, 32'h0000_0000);
    setw(12'h00A, 12'h003, 12'h003, 12'h003);
    fcnt(1'b1, 14, 5, 16'h0006);
    chk({16'h0000, first}, 32'h0000_0003);
  endtask

  task t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 2; o++) begin
        setw(12'h00A, {m[1:0], 10'h003}, 12'h003, 12'h000);
        fcnt(o[0], 14, 4, (m == 0) || (m == 2 && o == 1) || (m == 1 && o == 0) ?
             16'h000C : 16'h0000);
      end
    end
  endtask

  task t_drop;
    for (int k = 0; k < 3; k++) begin
      setw(12'h00A, 12'h004, 12'(2 * k), 12'h000);
      fcnt(1'b1, 15, 4, 16'(8 * k));
    end
  endtask

  task t_clamp;
    lines_per_field_i <= 9'h00C;
    setw(12'h00A, 12'h008, 12'h008, 12'h000);
    fcnt(1'b1, 16, 4, 16'h0008);
    lines_per_field_i <= 9'h00B;
    fcnt(1'b1, 16, 4, 16'h0004);
    setw(12'h00D, 12'h008, 12'h008, 12'h000);
    fcnt(1'b1, 16, 4, 16'h0000);
    lines_per_field_i <= 9'h014;
  endtask

  // With 1500 frames, only the count over a whole number of two-frame periods is checked, so the
  // accumulator left from earlier frames cannot change the outcome.
  task t_decim;
    logic [15:0] base;
    setw(12'h00A, 12'h201, 12'h001, 12'h000);
    wr(`VFW_IDX_DECIM, 12'h000);
    fcnt(1'b1, 12, 2, 16'h0000);
    fcnt(1'b0, 12, 2, 16'h0000);
    wr(`VFW_IDX_DECIM, 12'h5DC);
    base = cnt;
    repeat (4) begin
      fld(1'b1, 12, 2);
      fld(1'b0, 12, 2);
    end
    chk({16'h0000, cnt - base}, 32'h0000_0008);
    wr(`VFW_IDX_VSPAN, 12'h001);
    fcnt(1'b1, 12, 2, 16'h0002);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_window;
    t_modes;
    t_drop;
    t_clamp;
    t_decim;
    summarize;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    summarize;
  end
endmodule

bind vfw_window_selector vfw_window_selector_chk i_vfw_window_selector_chk (.clk_i,
  .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .vsync_i,
  .hsync_i, .field_odd_i, .pix_valid_i, .pix_data_i, .win_valid_o, .win_line_o,
  .win_data_o, .win_field_odd_o);
